// ==== dpt_map.svh ====
// dpt_map.svh: constants for the dual programmable timer
// assumes: included by the timer module only
`ifndef DPT_MAP_SVH
`define DPT_MAP_SVH

// ------------------------------------------------------------
// register offsets (plain port, word index)
// ------------------------------------------------------------
`define DPT_REG_CTRL      4'h0
`define DPT_REG_T0_MODE   4'h1
`define DPT_REG_T1_MODE   4'h2
`define DPT_REG_T0_RELOAD 4'h3
`define DPT_REG_T1_RELOAD 4'h4
`define DPT_REG_T0_COUNT  4'h5
`define DPT_REG_T1_COUNT  4'h6
`define DPT_REG_IRQ       4'h7

// ------------------------------------------------------------
// ctrl fields
// ------------------------------------------------------------
`define DPT_CTRL_T0_SRC   0
`define DPT_CTRL_T1_SRC   1
`define DPT_CTRL_OUT_EN   2
`define DPT_CTRL_CHAN     3
`define DPT_CTRL_CASCADE  4
`define DPT_CTRL_LATCH7   5
`define DPT_CTRL_LATCH6   6

// ------------------------------------------------------------
// mode fields (t0 and t1 share run/preload/continuous/div)
// ------------------------------------------------------------
`define DPT_MODE_RUN      0
`define DPT_MODE_PRELOAD  1
`define DPT_MODE_CONT     2
`define DPT_MODE_DIV_LO   3
`define DPT_MODE_DIV_HI   4
`define DPT_MODE_POL      5
`define DPT_MODE_FUNC     6
`define DPT_MODE_EVENT    7

// ------------------------------------------------------------
// irq fields: flags 0..1 (write 1 clears), enables 2..3, prio 4..7
// ------------------------------------------------------------
`define DPT_IRQ_FLAG0     0
`define DPT_IRQ_FLAG1     1
`define DPT_IRQ_EN0       2
`define DPT_IRQ_EN1       3
`define DPT_IRQ_PRIO0_LO  4
`define DPT_IRQ_PRIO1_LO  6

// ------------------------------------------------------------
// prescaler ratios, vectors, filter tick
// ------------------------------------------------------------
`define DPT_DIV_1         2'h0
`define DPT_DIV_4         2'h1
`define DPT_DIV_16        2'h2
`define DPT_DIV_64        2'h3
`define DPT_DIV_MAX       6'h3f
`define DPT_DIV_MASK_4    6'h03
`define DPT_DIV_MASK_16   6'h0f
`define DPT_VEC_T1        24'h000006
`define DPT_VEC_T0        24'h000008
`define DPT_FILT_EDGES    2'h2

`endif

// ==== dpt_pkg.sv ====
// dpt_pkg.sv: types for the dual programmable timer
// assumes: nothing; does not use the map header
package dpt_pkg;

	// per timer control bits
	typedef struct packed {
		logic       event_mode;
		logic       function_sel;
		logic       input_polarity;
		logic [1:0] div_sel;
		logic       continuous;
		logic       run;
	} dpt_tmr_cfg_t;

	// interrupt bits
	typedef struct packed {
		logic [1:0] prio1;
		logic [1:0] prio0;
		logic       en1;
		logic       en0;
		logic       flag1;
		logic       flag0;
	} dpt_irq_t;

	// whole state of the timer block
	typedef struct packed {
		logic [1:0]   rst_sync;
		dpt_tmr_cfg_t cfg0;
		dpt_tmr_cfg_t cfg1;
		logic         t0_src_sel;
		logic         t1_src_sel;
		logic         out_en;
		logic         out_chan;
		logic         cascade_16bit;
		logic         out_port_latch7;
		logic         out_port_latch6;
		logic [7:0]   reload0;
		logic [7:0]   reload1;
		logic [7:0]   count0;
		logic [7:0]   count1;
		logic [5:0]   pre0;
		logic [5:0]   pre1;
		dpt_irq_t     irq;
		logic [1:0]   in_sync;
		logic         in_prev;
		logic         filt_level;
		logic [1:0]   filt_cnt;
		logic         tick_sync;
		logic         tick_prev;
		logic         halfrate;
		logic [7:0]   rdata;
		logic         req0;
		logic         req1;
		logic         pin7;
		logic         pin6;
	} dpt_state_t;

endpackage

// ==== dpt_pulse_src.sv ====
// dpt_pulse_src.sv: pulse source on the external count input pin
// assumes: nothing about call timing; hold() waits for the next rising clock edge itself
`timescale 1ns/1ps
module dpt_pulse_src (
	input  wire logic clk_in,
	output logic      pin_out
);
	// idle high: the pin has a pull-up while no pulse is driven
	initial pin_out = 1'b1;

	task automatic hold(input logic lvl, input int n);
		@(posedge clk_in);
		pin_out <= lvl;
		repeat (n - 1) @(posedge clk_in);
	endtask
endmodule // dpt_pulse_src

// ==== dpt_timer.sv ====
// dpt_timer.sv: two 8-bit down timers, cascadable to 16 bits
// assumes: all inputs synchronous to MCLK_IN except ext input pin;
// oscillator inputs are enable-rate strobes in the MCLK_IN domain
//
// Behaviour
// - source-select 0 takes low-speed oscillator, 1 takes high-speed one
// - cascaded mode uses only timer 0 source select
// - ratio field 11/10/01/00 divides by 64/16/4/1
// - source reaches prescaler only while run bit set; output decrements
// - cascaded mode uses only timer 0 ratio field
// - event mode: timer 0 counts input edges; cascade gives 16-bit counter
// - event mode ignores timer 0 ratio field
// - event edge falling when polarity 0, rising when 1
// - noise filter counts at second 2048 Hz falling edge after change
// - function select without event mode gives pulse-width measurement
// - pulse-width counts prescaled clock only while input at polarity
// - underflow sets own flag; request only when enabled
// - each interrupt carries two-bit priority 0 to 3
// - timer 1 vector 000006h, timer 0 vector 000008h
// - cascaded mode never sets timer 0 flag; 16-bit underflow sets 1
// - half-rate output toggles on each selected underflow
// - channel bit picks timer 0/1; cascaded forces 16-bit underflow
// - enable 1 drives pin7 signal, pin6 inverse; else pin7 high, pin6 low (here pin7 is ANDed with latch7 bit, and is latch7 alone when off)
// - enable gates output unsynchronised; glitch up to half cycle (here the gating is registered, no glitch)
// - underflow reloads counter from reload register
// - one-shot: reload, stop, hardware clears run bit
// - cascade: timer 0 low, timer 1 high byte, timer 1 run held 0
// - writing 1 to preload copies reload value into counter
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "dpt_map.svh"

module dpt_timer (
	input  wire logic        MCLK_IN,
	input  wire logic        ARST_N_IN,
	input  wire logic        LOW_SPEED_OSC_IN,
	input  wire logic        HIGH_SPEED_OSC_IN,
	input  wire logic        TICK_2048_IN,
	input  wire logic        EXT_INPUT_PIN_IN,
	input  wire logic [3:0]  ADDR_IN,
	input  wire logic [7:0]  WDATA_IN,
	input  wire logic        WR_IN,
	input  wire logic        RD_IN,
	output logic      [7:0]  RDATA_OUT,
	output logic             T0_IRQ_REQ_OUT,
	output logic             T1_IRQ_REQ_OUT,
	output logic      [1:0]  T0_IRQ_PRIO_OUT,
	output logic      [1:0]  T1_IRQ_PRIO_OUT,
	output logic      [23:0] T0_IRQ_VEC_OUT,
	output logic      [23:0] T1_IRQ_VEC_OUT,
	output logic             T1_UNDERFLOW_OUT,
	output logic             OUT_PORT_PIN7_OUT,
	output logic             OUT_PORT_PIN6_OUT
);

	dpt_pkg::dpt_state_t s;
	dpt_pkg::dpt_state_t next_s;
	logic                rst_n;
	logic                src0;
	logic                src1;
	logic                tick0;
	logic                tick1;
	logic                ext_lvl;
	logic                ext_edge;
	logic                ext_act;
	logic                dec0;
	logic                dec1;
	logic                uf0;
	logic                uf1;
	logic                sel_uf;
	logic                wr_mode0;
	logic                wr_mode1;

	assign rst_n = s.rst_sync[1];

	// ------------------------------------------------------------
	// prescalers, input conditioning, counters
	// ------------------------------------------------------------
	function automatic logic pre_hit(input logic [1:0] d,
	                                 input logic [5:0] c);
		logic r;
		r = 1'b0;
		unique case (d)
			`DPT_DIV_1:  r = 1'b1;
			`DPT_DIV_4:  r = ((c & `DPT_DIV_MASK_4) == `DPT_DIV_MASK_4);
			`DPT_DIV_16: r = ((c & `DPT_DIV_MASK_16) == `DPT_DIV_MASK_16);
			`DPT_DIV_64: r = (c == `DPT_DIV_MAX);
		endcase
		return r;
	endfunction

	always_comb begin
		// source select, timer 0 bit in cascade
		src0 = s.t0_src_sel ? HIGH_SPEED_OSC_IN : LOW_SPEED_OSC_IN;
		src1 = s.cascade_16bit ? src0 :
		       (s.t1_src_sel ? HIGH_SPEED_OSC_IN : LOW_SPEED_OSC_IN);
		src0 = src0 & s.cfg0.run;
		src1 = src1 & s.cfg1.run;
		// ratio, timer 0 field in cascade
		tick0 = src0 & pre_hit(s.cfg0.div_sel, s.pre0);
		tick1 = src1 & pre_hit(s.cascade_16bit ? s.cfg0.div_sel
		                       : s.cfg1.div_sel, s.pre1);
		ext_lvl = s.cfg0.event_mode && s.cfg0.function_sel ?
		          s.filt_level : s.in_sync[1];
		// falling for polarity 0, rising for 1
		ext_edge = (s.in_prev != ext_lvl) &&
		           (ext_lvl == s.cfg0.input_polarity);
		ext_act = s.in_sync[1] == s.cfg0.input_polarity;
		if (s.cfg0.event_mode)
			dec0 = s.cfg0.run & ext_edge;
		// pulse width gated by input level
		else if (s.cfg0.function_sel)
			dec0 = tick0 & ext_act;
		else
			dec0 = tick0;
		uf0 = dec0 && (s.count0 == 8'h00);
		// cascade: high byte steps on low byte underflow
		if (s.cascade_16bit) begin
			dec1 = uf0;
			uf1 = uf0 && (s.count1 == 8'h00);
		end else begin
			dec1 = tick1;
			uf1 = dec1 && (s.count1 == 8'h00);
		end
		sel_uf = (s.cascade_16bit || s.out_chan) ? uf1 : uf0;
	end

	always_comb begin
		wr_mode0 = WR_IN && ADDR_IN == `DPT_REG_T0_MODE;
		wr_mode1 = WR_IN && ADDR_IN == `DPT_REG_T1_MODE;
		next_s = s;
		next_s.rst_sync = {s.rst_sync[0], 1'b1};
		next_s.in_sync = {s.in_sync[0], EXT_INPUT_PIN_IN};
		next_s.in_prev = ext_lvl;
		next_s.tick_sync = TICK_2048_IN;
		next_s.tick_prev = s.tick_sync;
		// accept change at second falling tick edge
		if (s.in_sync[1] == s.filt_level)
			next_s.filt_cnt = 2'h0;
		else if (s.tick_prev && !s.tick_sync) begin
			if (s.filt_cnt + 2'h1 == `DPT_FILT_EDGES) begin
				next_s.filt_level = s.in_sync[1];
				next_s.filt_cnt = 2'h0;
			end else
				next_s.filt_cnt = s.filt_cnt + 2'h1;
		end
		if (src0)
			next_s.pre0 = s.pre0 + 6'h01;
		if (src1)
			next_s.pre1 = s.pre1 + 6'h01;
		// reload on underflow; cascaded low byte borrows
		if (dec0)
			next_s.count0 = (uf0 && (uf1 || !s.cascade_16bit)) ?
			                s.reload0 : s.count0 - 8'h01;
		if (dec1)
			next_s.count1 = uf1 ? s.reload1 : s.count1 - 8'h01;
		if (uf0 && !s.cascade_16bit && !s.cfg0.continuous)
			next_s.cfg0.run = 1'b0;
		if (uf1 && !s.cfg0.continuous && s.cascade_16bit)
			next_s.cfg0.run = 1'b0;
		if (uf1 && !s.cascade_16bit && !s.cfg1.continuous)
			next_s.cfg1.run = 1'b0;
		if (sel_uf)
			next_s.halfrate = !s.halfrate;

		// register writes
		if (WR_IN) begin
			unique case (ADDR_IN)
				`DPT_REG_CTRL: begin
					next_s.t0_src_sel = WDATA_IN[`DPT_CTRL_T0_SRC];
					next_s.t1_src_sel = WDATA_IN[`DPT_CTRL_T1_SRC];
					next_s.out_en = WDATA_IN[`DPT_CTRL_OUT_EN];
					next_s.out_chan = WDATA_IN[`DPT_CTRL_CHAN];
					next_s.cascade_16bit = WDATA_IN[`DPT_CTRL_CASCADE];
					next_s.out_port_latch7 = WDATA_IN[`DPT_CTRL_LATCH7];
					next_s.out_port_latch6 = WDATA_IN[`DPT_CTRL_LATCH6];
				end
				`DPT_REG_T0_RELOAD: next_s.reload0 = WDATA_IN;
				`DPT_REG_T1_RELOAD: next_s.reload1 = WDATA_IN;
				`DPT_REG_IRQ: begin
					next_s.irq.en0 = WDATA_IN[`DPT_IRQ_EN0];
					next_s.irq.en1 = WDATA_IN[`DPT_IRQ_EN1];
					next_s.irq.prio0 = WDATA_IN[`DPT_IRQ_PRIO0_LO +: 2];
					next_s.irq.prio1 = WDATA_IN[`DPT_IRQ_PRIO1_LO +: 2];
					if (WDATA_IN[`DPT_IRQ_FLAG0])
						next_s.irq.flag0 = 1'b0;
					if (WDATA_IN[`DPT_IRQ_FLAG1])
						next_s.irq.flag1 = 1'b0;
				end
				default: ;
			endcase
		end
		if (wr_mode0) begin
			next_s.cfg0 = '{event_mode: WDATA_IN[`DPT_MODE_EVENT],
			    function_sel: WDATA_IN[`DPT_MODE_FUNC],
			    input_polarity: WDATA_IN[`DPT_MODE_POL],
			    div_sel: WDATA_IN[`DPT_MODE_DIV_HI:`DPT_MODE_DIV_LO],
			    continuous: WDATA_IN[`DPT_MODE_CONT],
			    run: WDATA_IN[`DPT_MODE_RUN]};
			if (WDATA_IN[`DPT_MODE_PRELOAD]) begin
				next_s.count0 = s.reload0;
				next_s.pre0 = 6'h00;
			end
		end
		if (wr_mode1) begin
			next_s.cfg1.div_sel = WDATA_IN[`DPT_MODE_DIV_HI:`DPT_MODE_DIV_LO];
			next_s.cfg1.continuous = WDATA_IN[`DPT_MODE_CONT];
			next_s.cfg1.run = WDATA_IN[`DPT_MODE_RUN];
			if (WDATA_IN[`DPT_MODE_PRELOAD]) begin
				next_s.count1 = s.reload1;
				next_s.pre1 = 6'h00;
			end
		end
		// timer 1 run held at 0 in cascade
		if (next_s.cascade_16bit)
			next_s.cfg1.run = 1'b0;
		// set beats clear; no timer 0 flag in cascade
		if (uf0 && !s.cascade_16bit)
			next_s.irq.flag0 = 1'b1;
		if (uf1)
			next_s.irq.flag1 = 1'b1;

		// request gated by enable, registered from next state
		next_s.req0 = next_s.irq.flag0 & next_s.irq.en0;
		next_s.req1 = next_s.irq.flag1 & next_s.irq.en1;
		// registered gating, so no glitch; pin6 latch ignored
		next_s.pin7 = next_s.out_port_latch7 &
		              (next_s.out_en ? next_s.halfrate : 1'b1);
		next_s.pin6 = next_s.out_en & !next_s.halfrate;

		// read data, registered: stands the cycle after the strobe
		next_s.rdata = 8'h00;
		if (RD_IN) begin
			unique case (ADDR_IN)
				`DPT_REG_CTRL: next_s.rdata = {1'b0, s.out_port_latch6,
				    s.out_port_latch7, s.cascade_16bit, s.out_chan,
				    s.out_en, s.t1_src_sel, s.t0_src_sel};
				`DPT_REG_T0_MODE: next_s.rdata = {s.cfg0.event_mode,
				    s.cfg0.function_sel, s.cfg0.input_polarity,
				    s.cfg0.div_sel, s.cfg0.continuous, 1'b0, s.cfg0.run};
				`DPT_REG_T1_MODE: next_s.rdata = {3'h0, s.cfg1.div_sel,
				    s.cfg1.continuous, 1'b0, s.cfg1.run};
				`DPT_REG_T0_RELOAD: next_s.rdata = s.reload0;
				`DPT_REG_T1_RELOAD: next_s.rdata = s.reload1;
				`DPT_REG_T0_COUNT: next_s.rdata = s.count0;
				`DPT_REG_T1_COUNT: next_s.rdata = s.count1;
				`DPT_REG_IRQ: next_s.rdata = s.irq;
				default: next_s.rdata = 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN)
			s <= '0;
		else if (!rst_n) begin
			s <= '0;
			s.rst_sync <= next_s.rst_sync;
		end else
			s <= next_s;
	end

	// ------------------------------------------------------------
	// outputs: all from flip-flops except the constant vectors
	// ------------------------------------------------------------
	assign RDATA_OUT = s.rdata;
	assign T0_IRQ_REQ_OUT = s.req0;
	assign T1_IRQ_REQ_OUT = s.req1;
	assign T0_IRQ_PRIO_OUT = s.irq.prio0;
	assign T1_IRQ_PRIO_OUT = s.irq.prio1;
	assign T0_IRQ_VEC_OUT = `DPT_VEC_T0;
	assign T1_IRQ_VEC_OUT = `DPT_VEC_T1;
	assign T1_UNDERFLOW_OUT = s.irq.flag1;
	// pin levels straight from their flops
	assign OUT_PORT_PIN7_OUT = s.pin7;
	assign OUT_PORT_PIN6_OUT = s.pin6;

endmodule // dpt_timer

// ==== dpt_timer_checker.sv ====
// dpt_timer_checker.sv: port assertions for the timer block
// assumes: bound to dpt_timer, one clock domain
`timescale 1ns/1ps
module dpt_timer_checker (
	input wire logic        MCLK_IN,
	input wire logic        ARST_N_IN,
	input wire logic [3:0]  ADDR_IN,
	input wire logic [7:0]  WDATA_IN,
	input wire logic        WR_IN,
	input wire logic        T0_IRQ_REQ_OUT,
	input wire logic        T1_IRQ_REQ_OUT,
	input wire logic [1:0]  T0_IRQ_PRIO_OUT,
	input wire logic [1:0]  T1_IRQ_PRIO_OUT,
	input wire logic [23:0] T0_IRQ_VEC_OUT,
	input wire logic [23:0] T1_IRQ_VEC_OUT,
	input wire logic        T1_UNDERFLOW_OUT,
	input wire logic        OUT_PORT_PIN7_OUT,
	input wire logic        OUT_PORT_PIN6_OUT
);
	logic casc;

	default clocking @(posedge MCLK_IN); endclocking
	default disable iff (!ARST_N_IN);

	// ----
	// helpers
	// ----
	// cascade bit mirrored from bus writes, same edge as the block
	always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			casc <= 1'b0;
		end else if (WR_IN && ADDR_IN == 4'h0) begin
			casc <= WDATA_IN[4];
		end
	end

	sequence ctrl_wr_s;
		WR_IN && ADDR_IN == 4'h0;
	endsequence
	sequence irq_wr_s;
		WR_IN && ADDR_IN == 4'h7;
	endsequence

	// ----
	// assertions
	// ----
	vec_const_a: assert property (
		T0_IRQ_VEC_OUT == 24'h000008 && T1_IRQ_VEC_OUT == 24'h000006)
		else $error("vector wrong");
	prio0_load_a: assert property (
		irq_wr_s |=> T0_IRQ_PRIO_OUT == $past(WDATA_IN[5:4]))
		else $error("t0 priority wrong");
	prio1_load_a: assert property (
		irq_wr_s |=> T1_IRQ_PRIO_OUT == $past(WDATA_IN[7:6]))
		else $error("t1 priority wrong");
	pin_excl_a: assert property (
		OUT_PORT_PIN6_OUT |-> !OUT_PORT_PIN7_OUT)
		else $error("pins not inverse");
	pin_off_a: assert property (
		ctrl_wr_s ##0 !WDATA_IN[2] |=> !OUT_PORT_PIN6_OUT &&
		OUT_PORT_PIN7_OUT == $past(WDATA_IN[5]))
		else $error("gated pins wrong");
	t1_req_flag_a: assert property (
		T1_IRQ_REQ_OUT |-> T1_UNDERFLOW_OUT)
		else $error("t1 request without flag");
	t0_req_en_a: assert property (
		irq_wr_s ##0 !WDATA_IN[2] |-> ##2 !T0_IRQ_REQ_OUT)
		else $error("t0 request while disabled");
	casc_no_t0_a: assert property (
		casc |-> !$rose(T0_IRQ_REQ_OUT))
		else $error("t0 request in cascade");
endmodule // dpt_timer_checker

bind dpt_timer dpt_timer_checker chk_u (
	.MCLK_IN(MCLK_IN),
	.ARST_N_IN(ARST_N_IN),
	.ADDR_IN(ADDR_IN),
	.WDATA_IN(WDATA_IN),
	.WR_IN(WR_IN),
	.T0_IRQ_REQ_OUT(T0_IRQ_REQ_OUT),
	.T1_IRQ_REQ_OUT(T1_IRQ_REQ_OUT),
	.T0_IRQ_PRIO_OUT(T0_IRQ_PRIO_OUT),
	.T1_IRQ_PRIO_OUT(T1_IRQ_PRIO_OUT),
	.T0_IRQ_VEC_OUT(T0_IRQ_VEC_OUT),
	.T1_IRQ_VEC_OUT(T1_IRQ_VEC_OUT),
	.T1_UNDERFLOW_OUT(T1_UNDERFLOW_OUT),
	.OUT_PORT_PIN7_OUT(OUT_PORT_PIN7_OUT),
	.OUT_PORT_PIN6_OUT(OUT_PORT_PIN6_OUT)
);

// ==== dpt_timer_tb_top.sv ====
// dpt_timer_tb_top.sv: self-checking bench for the timer block
// assumes: source strobes every cycle when on, tick period 16 cycles
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin \
	error_cnt++; $display("CHECK FAILED t=%0t got %0h exp %0h", \
	$time, a, e); end end
module dpt_timer_tb_top;
	logic        clk, rst_n, lo_on, hi_on, lo, hi, pin, h1, h2;
	logic        wr_en, rd_en, rq0, rq1, uf1, p7, p6;
	logic [3:0]  tk = 4'h0;
	logic [3:0]  addr;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	logic [7:0]  d;
	logic [1:0]  pr0;
	logic [1:0]  pr1;
	logic [23:0] v0;
	logic [23:0] v1;
	int          n;
	int          error_cnt;
	int          tests_run;

	// ----
	// plumbing
	// ----
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		lo <= lo_on;
		hi <= hi_on;
		tk <= tk + 4'h1;
	end

	dpt_timer dut_u (
		.MCLK_IN(clk),
		.ARST_N_IN(rst_n),
		.LOW_SPEED_OSC_IN(lo),
		.HIGH_SPEED_OSC_IN(hi),
		.TICK_2048_IN(tk[3]),
		.EXT_INPUT_PIN_IN(pin),
		.ADDR_IN(addr),
		.WDATA_IN(wdata),
		.WR_IN(wr_en),
		.RD_IN(rd_en),
		.RDATA_OUT(rdata),
		.T0_IRQ_REQ_OUT(rq0),
		.T1_IRQ_REQ_OUT(rq1),
		.T0_IRQ_PRIO_OUT(pr0),
		.T1_IRQ_PRIO_OUT(pr1),
		.T0_IRQ_VEC_OUT(v0),
		.T1_IRQ_VEC_OUT(v1),
		.T1_UNDERFLOW_OUT(uf1),
		.OUT_PORT_PIN7_OUT(p7),
		.OUT_PORT_PIN6_OUT(p6)
	);
	dpt_pulse_src src_u (.clk_in(clk), .pin_out(pin));

	task end_of_test;
		$display("errors=%0d checks=%0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task rd(input logic [3:0] a, output logic [7:0] q);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		// data stand only in the cycle after the strobe edge
		@(negedge clk);
		q = rdata;
	endtask
	task cr(input logic [3:0] a, input logic [7:0] e);
		rd(a, d);
		`CHK(d, e)
	endtask
	function automatic logic flg(input bit t1);
		return t1 ? uf1 : rq0;
	endfunction
	// period between two underflows, flags cleared at the first
	task meas(input bit t1, output int p);
		int w;
		wr(4'h7, 8'h0f);
		w = 0;
		@(negedge clk);
		while (flg(t1) !== 1'b1 && w < 2000) begin
			@(negedge clk);
			w++;
		end
		h1 = p7;
		// clear lands two edges after the flag rose; periods are longer
		wr(4'h7, 8'h0f);
		p = 2;
		@(negedge clk);
		while (flg(t1) !== 1'b1 && p < 2000) begin
			@(negedge clk);
			p++;
		end
		h2 = p7;
		if (w >= 2000 || p >= 2000) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t underflow timeout", $time);
			end_of_test;
		end
	endtask

	// ----
	// scenarios
	// ----
	task t_reset;
		wr(4'hf, 8'hff);
		for (int a = 0; a < 16; a++) cr(a[3:0], 8'h00);
		`CHK(p7, 1'b0)
		`CHK(v0, 24'h000008)
		`CHK(v1, 24'h000006)
	endtask
	task t_prio;
		for (int p = 0; p < 4; p++) begin
			wr(4'h7, {2'(3 - p), 2'(p), 4'h0});
			@(posedge clk);
			`CHK(pr0, 2'(p))
			`CHK(pr1, 2'(3 - p))
		end
		wr(4'h0, 8'h04);
		@(posedge clk);
		`CHK(p7, 1'b0)
		`CHK(p6, 1'b1)
	endtask
	task t_ratio;
		lo_on <= 1'b1;
		wr(4'h0, 8'h2c);
		wr(4'h4, 8'h03);
		for (int k = 0; k < 4; k++) begin
			wr(4'h2, {3'h0, 2'(k), 3'h7});
			meas(1'b1, n);
			`CHK(n, 4 << (2 * k))
			`CHK(h2, ~h1)
			`CHK(p6, ~p7)
		end
	endtask
	task t_chan;
		wr(4'h0, 8'h24);
		meas(1'b1, n);
		`CHK(h2, h1)
		wr(4'h3, 8'h03);
		wr(4'h1, 8'h0f);
		meas(1'b0, n);
		`CHK(n, 16)
		`CHK(h2, ~h1)
		wr(4'h1, 8'h00);
		wr(4'h2, 8'h02);
	endtask
	task t_src;
		lo_on <= 1'b0;
		hi_on <= 1'b1;
		wr(4'h2, 8'h07);
		repeat (20) @(posedge clk);
		cr(4'h6, 8'h03);
		wr(4'h0, 8'h26);
		meas(1'b1, n);
		`CHK(n, 4)
		wr(4'h2, 8'h02);
		repeat (20) @(posedge clk);
		cr(4'h6, 8'h03);
	endtask
	task t_casc;
		lo_on <= 1'b1;
		hi_on <= 1'b0;
		wr(4'h7, 8'h0f);
		wr(4'h0, 8'h36);
		wr(4'h3, 8'h01);
		wr(4'h4, 8'h01);
		wr(4'h2, 8'h1b);
		wr(4'h1, 8'h07);
		meas(1'b1, n);
		`CHK(n, 258)
		`CHK(h2, ~h1)
		`CHK(rq0, 1'b0)
		`CHK(rq1, 1'b1)
		cr(4'h2, 8'h18);
		wr(4'h1, 8'h00);
		wr(4'h0, 8'h20);
	endtask
	task t_oneshot;
		wr(4'h4, 8'h03);
		wr(4'h2, 8'h03);
		repeat (20) @(posedge clk);
		cr(4'h2, 8'h00);
		cr(4'h6, 8'h03);
	endtask
	task t_event;
		wr(4'h3, 8'h05);
		wr(4'h1, 8'h87);
		src_u.hold(1'b0, 8);
		cr(4'h5, 8'h04);
		src_u.hold(1'b1, 8);
		cr(4'h5, 8'h04);
		wr(4'h1, 8'ha7);
		src_u.hold(1'b0, 8);
		cr(4'h5, 8'h05);
		src_u.hold(1'b1, 8);
		cr(4'h5, 8'h04);
	endtask
	task t_filter;
		wr(4'h1, 8'hc7);
		src_u.hold(1'b0, 6);
		src_u.hold(1'b1, 40);
		cr(4'h5, 8'h05);
		src_u.hold(1'b0, 40);
		cr(4'h5, 8'h04);
	endtask
	task t_pw;
		src_u.hold(1'b1, 10);
		wr(4'h3, 8'hff);
		wr(4'h1, 8'h47);
		cr(4'h5, 8'hff);
		src_u.hold(1'b0, 10);
		src_u.hold(1'b1, 10);
		cr(4'h5, 8'hf5);
	endtask

	initial begin
		rst_n = 1'b0;
		{lo_on, hi_on, wr_en, rd_en} = 4'h0;
		addr = 4'h0;
		wdata = 8'h00;
		error_cnt = 0;
		tests_run = 0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset;
		t_prio;
		t_ratio;
		t_chan;
		t_src;
		t_casc;
		t_oneshot;
		t_event;
		t_filter;
		t_pw;
		end_of_test;
	end
endmodule // dpt_timer_tb_top
